// File: hw/servo_auto_sequencer.sv
`timescale 1ns/1ps
`include "servo_params.svh"
module servo_auto_sequencer
	import servo_pkg::*;
#(
	parameter logic [15:0] HOLD_CYCLES = 16'(`HOLD_CYCLES)
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_latch_clock,
	input  wire logic        focus_ok,
	input  wire logic        focus_zero_cross,
	input  wire logic        track_count_pulse,
	input  wire logic        mirror_signal,
	output logic             seq_busy_n,
	output logic             focus_search_up,
	output logic             focus_servo_on,
	output logic             tracking_servo_on,
	output logic             sled_servo_on,
	output logic             act_kick_fwd,
	output logic             act_kick_rev,
	output logic             sled_kick_fwd,
	output logic             sled_kick_rev,
	output logic      [11:0] servo_cmd,
	output logic             servo_cmd_valid
);
	seq_core_t   q;
	seq_core_t   d;
	logic        tick;
	logic        track_edge;
	logic        slow;
	logic        wr;
	logic        wr_cmd;
	logic        start;
	logic        cancel;
	logic        done_ivl;
	logic        counted;
	logic [3:0]  sel;
	logic [15:0] unit;
	seq_state_t  entry;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `OFS_CMD) || (a == `OFS_TIME) || (a == `OFS_KICK) || (a == `OFS_JUMPN) ||
			(a == `OFS_TRAV) || (a == `OFS_CTRL) || (a == `OFS_STATUS);
	endfunction

	// Returns {fwd, rev}; back flips the kick against the travel direction
	function automatic logic [1:0] drive(input logic on, input logic back, input logic r);
		if (!on) begin
			drive = 2'b00;
		end else begin
			drive = (back ^ r) ? 2'b01 : 2'b10;
		end
	endfunction

	function automatic seq_state_t first_state(input logic [3:0] s);
		unique case (s)
			4'h7:        first_state = S_AF_SEARCH;
			4'h8, 4'h9:  first_state = S_J1_KICK;
			4'ha, 4'hb:  first_state = S_JK_KICK;
			4'hc, 4'hd:  first_state = S_JK_KICK;
			4'h4, 4'h5:  first_state = S_FS_KICK;
			4'he, 4'hf:  first_state = S_MV_MOVE;
			default:     first_state = S_IDLE;
		endcase
	endfunction

	seq_tick_div u_tick (
		.clock (clock),
		.rstn  (rstn),
		.tick  (tick)
	);

	track_period_mon u_mon (
		.clock             (clock),
		.rstn              (rstn),
		.tick              (tick),
		.clear             (start),
		.use_mirror_signal          (q.use_mirror_signal),
		.overflow          ((q.st == S_FS_TRAV) ? q.kick_r[`F_OVF_G] : q.time_r[`F_OVF_C]),
		.track_count_pulse (track_count_pulse),
		.mirror_signal     (mirror_signal),
		.track_edge        (track_edge),
		.slow              (slow)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.cmd_valid = 1'b0;
		d.latch_q = serial_latch_clock;
		d.fzc_q = focus_zero_cross;
		sel = pwdata[`F_CMD_SEL];
		wr = psel && penable && q.pready && pwrite && !q.pslverr;
		wr_cmd = wr && (paddr == `OFS_CMD);
		entry = first_state(sel);
		cancel = wr_cmd && pwdata[`F_CMD_GRP] == `GRP_AUTO && sel == `SEL_CANCEL;
		// Auto commands start only when enabled and in S_IDLE; while a sequence runs all but cancel are ignored
		start = wr_cmd && pwdata[`F_CMD_GRP] == `GRP_AUTO && entry != S_IDLE &&
			q.st == S_IDLE && q.aseq_en;
		unit = pwdata[3] ? `MAXT_UNIT_LONG : `MAXT_UNIT_SHORT;
		done_ivl = tick && q.ivl == 8'h00;
		counted = track_edge && (q.tcnt + 16'h0001 >= q.target);

		// Zero-wait slave: answer in the first access cycle
		if (psel && !penable && !q.pready) begin
			d.pready = 1'b1;
			d.pslverr = !addr_ok(paddr);
			unique case (paddr)
				`OFS_CMD:    d.prdata = {20'h00000, q.cmd};
				`OFS_TIME:   d.prdata = q.time_r;
				`OFS_KICK:   d.prdata = {8'h00, q.kick_r};
				`OFS_JUMPN:  d.prdata = {16'h0000, q.jump_n};
				`OFS_TRAV:   d.prdata = {16'h0000, q.trav_n};
				`OFS_CTRL:   d.prdata = {31'h0, q.aseq_en};
				`OFS_STATUS: d.prdata = {~q.busy_n, 10'h000, q.comp, q.st, q.tcnt};
				default:     d.prdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				`OFS_TIME:  d.time_r = pwdata;
				`OFS_KICK:  d.kick_r = pwdata[23:0];
				`OFS_JUMPN: d.jump_n = pwdata[15:0];
				`OFS_TRAV:  d.trav_n = pwdata[15:0];
				`OFS_CTRL:  d.aseq_en = pwdata[0];
				default:    d.aseq_en = q.aseq_en;
			endcase
		end
		if (wr_cmd && pwdata[`F_CMD_GRP] != `GRP_AUTO &&
			!(!q.busy_n && pwdata[`F_CMD_GRP] <= `GRP_LAST_LOW)) begin
			d.cmd = pwdata[11:0];
			d.cmd_valid = 1'b1;
		end

		// ----------------------------------------
		// Sequencer
		// ----------------------------------------
		if (start) begin
			d.st = entry;
			d.rev = sel[0] && sel != 4'h7;
			d.tcnt = 16'h0000;
			d.is_2n = sel[3:1] == 3'h6;
			d.target = (sel[3:1] == 3'h5) ? `TEN_JUMP_BRAKE : q.jump_n;
			d.use_mirror_signal = (sel[3:1] == 3'h6 || sel[3:1] == 3'h7) && q.jump_n >= `MIRROR_MIN;
			d.maxt = 16'(pwdata[2:0] * unit);
			d.maxt_en = pwdata[2:0] != 3'h0;
			d.comp = q.trav_n != 16'h0000;
			if (entry == S_J1_KICK) begin
				d.ivl = q.time_r[`F_BLIND_A];
			end else begin
				d.ivl = q.kick_r[`F_KICK_F];
			end
			if (entry == S_JK_KICK || entry == S_FS_KICK || entry == S_MV_MOVE) begin
				d.track_on = 1'b0;
				d.sled_on = 1'b0;
			end
		end else begin
			if (tick && q.ivl != 8'h00) begin
				d.ivl = q.ivl - 8'h01;
			end
			if (track_edge) begin
				d.tcnt = q.tcnt + 16'h0001;
			end
			unique case (q.st)
				S_IDLE: d.st = S_IDLE;
				S_AF_SEARCH: begin
					if (focus_ok && focus_zero_cross) begin
						d.st = S_AF_HIGH;
						d.ivl = q.time_r[`F_BLIND_E];
					end
				end
				S_AF_HIGH: begin
					// Chatter on zero-cross restarts the blind window
					if (!focus_zero_cross) begin
						d.st = S_AF_SEARCH;
					end else if (done_ivl) begin
						d.st = S_AF_FALL;
					end
				end
				S_AF_FALL: begin
					if (q.fzc_q && !focus_zero_cross) begin
						d.focus_on = 1'b1;
						d.st = S_IDLE;
					end
				end
				S_J1_KICK: begin
					if (done_ivl) begin
						d.st = S_J1_BRAKE;
						d.ivl = q.time_r[`F_BRAKE_B];
					end
				end
				S_J1_BRAKE: begin
					if (done_ivl) begin
						d.track_on = 1'b1;
						d.st = S_IDLE;
					end
				end
				S_JK_KICK: begin
					if (counted) begin
						d.st = S_JK_BRAKE;
					end
				end
				S_JK_BRAKE: begin
					if (slow) begin
						d.track_on = 1'b1;
						if (q.is_2n) begin
							d.st = S_J2_SLED;
							d.ivl = q.kick_r[`F_KICK_D];
						end else begin
							d.sled_on = 1'b1;
							d.st = S_IDLE;
						end
					end
				end
				S_J2_SLED: begin
					if (done_ivl) begin
						d.sled_on = 1'b1;
						d.st = S_IDLE;
					end
				end
				S_FS_KICK: begin
					if (done_ivl) begin
						d.st = S_FS_TRAV;
					end
				end
				S_FS_TRAV: begin
					if (track_edge && q.tcnt + 16'h0001 >= q.trav_n) begin
						d.comp = 1'b0;
					end
					if (counted) begin
						d.track_on = 1'b1;
						d.ivl = q.kick_r[`F_KICK_D];
						d.st = S_FS_BRAKE;
					end
				end
				S_FS_BRAKE: begin
					if (done_ivl) begin
						d.sled_on = 1'b1;
						d.st = S_IDLE;
					end
				end
				S_MV_MOVE: begin
					// Servos stay open; the host closes them once settled
					if (counted) begin
						d.st = S_IDLE;
					end
				end
			endcase
			if (q.st != S_IDLE && q.maxt_en && tick) begin
				d.maxt = q.maxt - 16'h0001;
				if (q.maxt == 16'h0001) begin
					d.st = S_IDLE;
				end
			end
			if (cancel) begin
				d.st = S_IDLE;
			end
		end

		// ----------------------------------------
		// Drive outputs from the next state
		// ----------------------------------------
		d.search_up = d.st == S_AF_SEARCH || d.st == S_AF_HIGH || d.st == S_AF_FALL;
		d.act = 2'b00;
		d.sled = 2'b00;
		unique case (d.st)
			S_J1_KICK:  d.act = drive(1'b1, 1'b0, d.rev);
			S_J1_BRAKE: d.act = drive(1'b1, 1'b1, d.rev);
			S_JK_KICK: begin
				d.act = drive(1'b1, 1'b0, d.rev);
				d.sled = drive(1'b1, 1'b0, d.rev);
			end
			S_JK_BRAKE: begin
				d.act = drive(1'b1, 1'b1, d.rev);
				d.sled = drive(1'b1, 1'b0, d.rev);
			end
			S_J2_SLED: d.sled = drive(1'b1, 1'b0, d.rev);
			S_FS_KICK: begin
				d.act = drive(1'b1, 1'b0, d.rev);
				d.sled = drive(1'b1, 1'b0, d.rev);
			end
			S_FS_TRAV: begin
				// Too fast means brake; slower than G means push
				d.act = drive(1'b1, !slow, d.rev);
				d.sled = drive(d.comp, 1'b0, d.rev);
			end
			S_FS_BRAKE: d.sled = drive(1'b1, 1'b1, d.rev);
			S_MV_MOVE:  d.sled = drive(1'b1, 1'b0, d.rev);
			default:    d.act = 2'b00;
		endcase

		// Busy may not rise until the hold window after a latch edge ends
		if (serial_latch_clock && !q.latch_q && !q.busy_n) begin
			d.hold = HOLD_CYCLES;
		end else if (q.hold != 16'h0000) begin
			d.hold = q.hold - 16'h0001;
		end
		d.busy_n = !(d.st != S_IDLE || d.hold != 16'h0000);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.busy_n <= 1'b1;
			q.time_r <= `TIME_RST;
			q.kick_r <= `KICK_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign seq_busy_n = q.busy_n;
	assign focus_search_up = q.search_up;
	assign focus_servo_on = q.focus_on;
	assign tracking_servo_on = q.track_on;
	assign sled_servo_on = q.sled_on;
	assign act_kick_fwd = q.act[1];
	assign act_kick_rev = q.act[0];
	assign sled_kick_fwd = q.sled[1];
	assign sled_kick_rev = q.sled[0];
	assign servo_cmd = q.cmd;
	assign servo_cmd_valid = q.cmd_valid;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_latch_busy;
		$rose(serial_latch_clock) && !seq_busy_n;
	endsequence
	sequence s_af_fall;
		q.st == S_AF_FALL && q.fzc_q && !focus_zero_cross && !cancel;
	endsequence

	low_group_drop_a: assert property (wr_cmd && !seq_busy_n && pwdata[11:8] <= 4'h3 |=> !servo_cmd_valid)
		else $error("low group command passed while busy");
	high_group_pass_a: assert property (wr_cmd && pwdata[11:8] >= 4'h5 && pwdata[11:8] <= 4'he
		|=> servo_cmd_valid && servo_cmd == $past(pwdata[11:0]))
		else $error("high group command not forwarded");
	busy_hold_a: assert property (s_latch_busy |=> !seq_busy_n [*8])
		else $error("busy released inside latch hold window");
	max_abort_a: assert property (q.st != S_IDLE && q.maxt_en && q.maxt == 16'h0001 && tick && !start
		|=> q.st == S_IDLE)
		else $error("max timer expiry did not abort");
	timer_off_a: assert property (start && pwdata[2:0] == 3'h0 |=> !q.maxt_en)
		else $error("zero timer field left supervision on");
	af_close_a: assert property (s_af_fall |=> focus_servo_on && !focus_search_up)
		else $error("focus not closed on zero-cross fall");
	one_jump_kick_a: assert property (q.st == S_J1_KICK |-> act_kick_fwd != act_kick_rev)
		else $error("actuator not kicked in one-track jump");
	ten_brake_a: assert property (q.st == S_JK_KICK && !q.is_2n && track_edge && q.tcnt == 16'h0004 && !cancel
		&& !(q.maxt_en && q.maxt == 16'h0001 && tick) |=> q.st == S_JK_BRAKE)
		else $error("ten-track brake not after 5 pulses");
	settle_close_a: assert property (q.st == S_JK_BRAKE && slow && !q.is_2n && !cancel
		|=> tracking_servo_on && sled_servo_on && seq_busy_n == (q.hold == 16'h0000))
		else $error("servos not closed after slow period");
endmodule

// File: pkg/servo_params.svh
`ifndef SERVO_PARAMS_SVH
`define SERVO_PARAMS_SVH
// Functional notes
// - Busy: drop groups 0-3, pass 5-F
// - Latch edge holds busy low 100us
// - Max timer expiry aborts like cancel
// - Timer field zero disables max timer
// - Auto focus closes on late zero-cross fall
// - One-track jump uses blind A, brake B
// - Ten-track: brake actuator after 5 pulses
// - Close servos when pulse period exceeds C
// - 2N count: pulses below 16, else mirror
// - 2N: sled driven for D after close
// - Fine search kicks, regulates against G
// - Traverse compare falls at register B count
// - Fine search brake: reverse sled kick D
// - M move: sled only, servos off after

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS          10
`define TICK_NS         10000
`define TICK_CYCLES     (`TICK_NS / `CLK_NS)
`define HOLD_US         100
`define HOLD_CYCLES     ((`HOLD_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define MAXT_UNIT_SHORT 16'h0064
`define MAXT_UNIT_LONG  16'h03e8
`define TEN_JUMP_BRAKE  16'h0005
`define MIRROR_MIN      16'h0010

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CMD    8'h00
`define OFS_TIME   8'h04
`define OFS_KICK   8'h08
`define OFS_JUMPN  8'h0c
`define OFS_TRAV   8'h10
`define OFS_CTRL   8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define F_BLIND_A    7:0
`define F_BRAKE_B    15:8
`define F_OVF_C      23:16
`define F_BLIND_E    31:24
`define F_KICK_D     7:0
`define F_KICK_F     15:8
`define F_OVF_G      23:16
`define F_CMD_GRP    11:8
`define F_CMD_SEL    7:4
`define F_CMD_TMR    3:0
`define TIME_RST     32'h0000_0000
`define KICK_RST     24'h00_0000
`define GRP_AUTO     4'h4
`define GRP_LAST_LOW 4'h3
`define SEL_CANCEL   4'h0
`endif

// File: pkg/servo_pkg.sv
package servo_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_AF_SEARCH, S_AF_HIGH, S_AF_FALL, S_J1_KICK, S_J1_BRAKE, S_JK_KICK,
		S_JK_BRAKE, S_J2_SLED, S_FS_KICK, S_FS_TRAV, S_FS_BRAKE, S_MV_MOVE
	} seq_state_t;

	typedef struct packed {
		logic [9:0] cnt;
		logic       tick;
	} tick_div_t;

	typedef struct packed {
		logic       track_count_pulse_q;
		logic       mirror_signal_q;
		logic [7:0] period;
		logic       edge_p;
		logic       slow;
	} track_mon_t;

	typedef struct packed {
		seq_state_t  st;
		logic        rev;
		logic        is_2n;
		logic        use_mirror_signal;
		logic [15:0] tcnt;
		logic [15:0] target;
		logic [7:0]  ivl;
		logic [15:0] maxt;
		logic        maxt_en;
		logic [15:0] hold;
		logic        latch_q;
		logic        fzc_q;
		logic [31:0] time_r;
		logic [23:0] kick_r;
		logic [15:0] jump_n;
		logic [15:0] trav_n;
		logic        aseq_en;
		logic        comp;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        busy_n;
		logic        search_up;
		logic        focus_on;
		logic        track_on;
		logic        sled_on;
		logic [1:0]  act;
		logic [1:0]  sled;
		logic [11:0] cmd;
		logic        cmd_valid;
	} seq_core_t;
endpackage

// File: hw/seq_tick_div.sv
`timescale 1ns/1ps
`include "servo_params.svh"
module seq_tick_div
	import servo_pkg::*;
(
	input  wire logic clock,
	input  wire logic rstn,
	output logic      tick
);
	tick_div_t q;
	tick_div_t d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 10'(`TICK_CYCLES - 1)) begin
			d.cnt = 10'h000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 10'h001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule

// File: hw/track_period_mon.sv
`timescale 1ns/1ps
`include "servo_params.svh"
module track_period_mon
	import servo_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic       use_mirror_signal,
	input  wire logic [7:0] overflow,
	input  wire logic       track_count_pulse,
	input  wire logic       mirror_signal,
	output logic            track_edge,
	output logic            slow
);
	track_mon_t q;
	track_mon_t d;
	logic       rise;

	always_comb begin
		d = q;
		d.edge_p = 1'b0;
		d.track_count_pulse_q = track_count_pulse;
		d.mirror_signal_q = mirror_signal;
		rise = track_count_pulse & ~q.track_count_pulse_q;
		if (clear) begin
			d.period = 8'h00;
			d.slow = 1'b0;
		end else begin
			if (rise) begin
				d.period = 8'h00;
			end else if (tick && q.period != 8'hff) begin
				d.period = q.period + 8'h01;
			end
			// Mirror counts both transitions of each track
			d.edge_p = use_mirror_signal ? (mirror_signal ^ q.mirror_signal_q) : rise;
			d.slow = d.period > overflow;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign track_edge = q.edge_p;
	assign slow = q.slow;
endmodule

// File: verification/servo_host_model.sv
`timescale 1ns/1ps
module servo_host_model #(
	parameter logic [11:0] FOCUS_DOWN_CMD = 12'h020,
	parameter logic [11:0] GAIN_BRAKE_CMD = 12'h170
) (
	input  wire logic        clock,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             serial_latch_clock
);
	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	logic aseq_on;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		serial_latch_clock = 1'b0;
		aseq_on = 1'b0;
	end

	// Caller enters right after a rising edge; only the bench timeout ends a wait
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines show garbage, not the last value
		paddr <= ~a;
		pwdata <= ~d;
		if (wr && a == 8'h14)
			aseq_on = d[0];
		// Idle cycle so a following setup never rewrites psel in this time step
		@(posedge clock);
	endtask

	// ----------------------------------------
	// Host command habits
	// ----------------------------------------
	task automatic send_cmd(input logic [11:0] c);
		logic [31:0] r;
		logic        e;
		if (c[11:8] == 4'h4 && !aseq_on)
			xfer(1'b1, 8'h14, 32'h1, r, e);
		if (c[11:4] == 8'h47)
			xfer(1'b1, 8'h00, {20'h0, FOCUS_DOWN_CMD}, r, e);
		if (c[11:4] >= 8'h48 && c[11:4] <= 8'h4d)
			xfer(1'b1, 8'h00, {20'h0, GAIN_BRAKE_CMD}, r, e);
		xfer(1'b1, 8'h00, {20'h0, c}, r, e);
	endtask

	task automatic latch_pulse();
		serial_latch_clock <= ~serial_latch_clock;
		repeat (2) @(posedge clock);
		serial_latch_clock <= ~serial_latch_clock;
	endtask
endmodule

// File: verification/servo_auto_sequencer_test.sv
`timescale 1ns/1ps
module servo_auto_sequencer_test;
	import servo_pkg::*;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr, serial_latch_clock;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        focus_ok, focus_zero_cross, track_count_pulse, mirror_signal, er;
	logic        seq_busy_n, focus_search_up, focus_servo_on, tracking_servo_on, sled_servo_on;
	logic        act_kick_fwd, act_kick_rev, sled_kick_fwd, sled_kick_rev, servo_cmd_valid;
	logic [11:0] servo_cmd;
	int          bad_count, checked, cycles, vcount, v0;

	servo_host_model u_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .serial_latch_clock);

	servo_auto_sequencer #(.HOLD_CYCLES(16'd50)) u_dut (.clock, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .serial_latch_clock, .focus_ok,
		.focus_zero_cross, .track_count_pulse, .mirror_signal, .seq_busy_n, .focus_search_up,
		.focus_servo_on, .tracking_servo_on, .sled_servo_on, .act_kick_fwd, .act_kick_rev,
		.sled_kick_fwd, .sled_kick_rev, .servo_cmd, .servo_cmd_valid);

	// ----------------------------------------
	// Clock, watchdog, helpers
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Whole run needs about 20k cycles; a stuck wait is cut at 60k
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (servo_cmd_valid === 1'b1)
			vcount = vcount + 1;
		if (cycles == 60000) begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (seq_busy_n !== lvl && n < lim) begin
			@(posedge clock);
			n++;
		end
		check(32'(seq_busy_n), 32'(lvl), "busy level");
	endtask

	task automatic pulses(input int k);
		repeat (k) begin
			track_count_pulse <= ~track_count_pulse;
			repeat (20) @(posedge clock);
			track_count_pulse <= ~track_count_pulse;
			repeat (20) @(posedge clock);
		end
	endtask

	task automatic mirrors(input int k);
		repeat (k) begin
			mirror_signal <= ~mirror_signal;
			repeat (20) @(posedge clock);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		focus_ok = 1'b0;
		focus_zero_cross = 1'b0;
		track_count_pulse = 1'b0;
		mirror_signal = 1'b0;
		bad_count = 0;
		checked = 0;
		cycles = 0;
		vcount = 0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		check(32'(seq_busy_n), 32'h1, "busy after reset");
		u_host.xfer(1'b0, 8'h1c, 32'h0, rd, er);
		check(32'(er), 32'h1, "unmapped read error");
		u_host.xfer(1'b0, 8'h14, 32'h0, rd, er);
		check(rd, 32'h0, "enable reset value");
		// Auto command before enable must not start
		u_host.xfer(1'b1, 8'h00, 32'h470, rd, er);
		repeat (5) @(posedge clock);
		check(32'(seq_busy_n), 32'h1, "start without enable");
		u_host.xfer(1'b1, 8'h04, 32'h0102_0101, rd, er);
		// Auto focus: chatter first, then a long high
		u_host.send_cmd(12'h470);
		wait_busy(1'b0, 10);
		check(32'(focus_search_up), 32'h1, "search up");
		focus_ok <= 1'b1;
		focus_zero_cross <= 1'b1;
		repeat (200) @(posedge clock);
		focus_zero_cross <= 1'b0;
		repeat (50) @(posedge clock);
		check(32'(focus_servo_on), 32'h0, "short zero-cross");
		focus_zero_cross <= 1'b1;
		repeat (3500) @(posedge clock);
		focus_zero_cross <= 1'b0;
		wait_busy(1'b1, 100);
		check(32'(focus_servo_on), 32'h1, "focus closed");
		// Reverse one-track jump, commands sent while busy
		u_host.send_cmd(12'h490);
		wait_busy(1'b0, 10);
		repeat (3) @(posedge clock);
		check(32'(act_kick_rev), 32'h1, "reverse kick");
		v0 = vcount;
		u_host.xfer(1'b1, 8'h00, 32'h123, rd, er);
		repeat (4) @(posedge clock);
		check(32'(vcount - v0), 32'h0, "low group dropped");
		u_host.xfer(1'b1, 8'h00, 32'h5ab, rd, er);
		repeat (4) @(posedge clock);
		check(32'(vcount - v0), 32'h1, "high group passed");
		check(32'(servo_cmd), 32'h5ab, "forwarded command");
		wait_busy(1'b1, 6000);
		check(32'({act_kick_fwd, act_kick_rev}), 32'h0, "kicks off");
		// Ten-track forward jump
		u_host.send_cmd(12'h4a0);
		wait_busy(1'b0, 10);
		repeat (3) @(posedge clock);
		check(32'({act_kick_fwd, sled_kick_fwd}), 32'h3, "actuator and sled kick");
		pulses(4);
		check(32'(act_kick_fwd), 32'h1, "still kicking at four");
		pulses(1);
		check(32'({act_kick_rev, sled_kick_fwd}), 32'h3, "brake at five");
		wait_busy(1'b1, 8000);
		check(32'({tracking_servo_on, sled_servo_on}), 32'h3, "servos closed");
		// Sled-only move of three tracks
		u_host.xfer(1'b1, 8'h0c, 32'h3, rd, er);
		u_host.send_cmd(12'h4e0);
		wait_busy(1'b0, 10);
		repeat (3) @(posedge clock);
		check(32'({act_kick_fwd, act_kick_rev, sled_kick_fwd}), 32'h1, "sled only");
		pulses(3);
		wait_busy(1'b1, 100);
		check(32'({tracking_servo_on, sled_servo_on}), 32'h0, "servos off after move");
		u_host.send_cmd(12'h250);
		// Fine search of six tracks, monitor count four, G slowed on the fall
		u_host.xfer(1'b1, 8'h0c, 32'h6, rd, er);
		u_host.xfer(1'b1, 8'h10, 32'h4, rd, er);
		u_host.xfer(1'b1, 8'h08, 32'h0005_0101, rd, er);
		u_host.send_cmd(12'h440);
		wait_busy(1'b0, 10);
		repeat (3) @(posedge clock);
		check(32'({act_kick_fwd, sled_kick_fwd}), 32'h3, "search kick");
		repeat (2100) @(posedge clock);
		check(32'({act_kick_rev, sled_kick_fwd}), 32'h3, "traverse braked, sled pushed");
		pulses(4);
		check(32'({sled_kick_fwd, sled_kick_rev}), 32'h0, "sled off after compare fall");
		u_host.xfer(1'b1, 8'h08, 32'h0002_0101, rd, er);
		pulses(2);
		check(32'({tracking_servo_on, sled_kick_rev}), 32'h3, "brake after N");
		wait_busy(1'b1, 2500);
		check(32'({tracking_servo_on, sled_servo_on}), 32'h3, "servos closed after search");
		// 2N jump of sixteen, counted on mirror transitions
		u_host.xfer(1'b1, 8'h0c, 32'h10, rd, er);
		u_host.send_cmd(12'h4c0);
		wait_busy(1'b0, 10);
		mirrors(15);
		check(32'(act_kick_fwd), 32'h1, "kicking before sixteen");
		mirrors(1);
		check(32'({act_kick_rev, sled_kick_fwd}), 32'h3, "brake at sixteen");
		for (int i = 0; i < 4000 && tracking_servo_on !== 1'b1; i++)
			@(posedge clock);
		check(32'({tracking_servo_on, sled_servo_on, sled_kick_fwd}), 32'h5, "sled driven after close");
		wait_busy(1'b1, 2500);
		check(32'(sled_servo_on), 32'h1, "sled closed after D");
		// Cancel in mid-sequence
		focus_ok <= 1'b0;
		u_host.send_cmd(12'h470);
		wait_busy(1'b0, 10);
		u_host.xfer(1'b1, 8'h00, 32'h400, rd, er);
		wait_busy(1'b1, 5);
		// Latch edge while busy holds busy past the cancel
		u_host.send_cmd(12'h470);
		wait_busy(1'b0, 10);
		u_host.latch_pulse();
		u_host.xfer(1'b1, 8'h00, 32'h400, rd, er);
		repeat (30) @(posedge clock);
		check(32'(seq_busy_n), 32'h0, "busy held after latch");
		wait_busy(1'b1, 60);
		end_of_test();
	end
endmodule
